// ---- rtl/ufl_consts.vh ----
`ifndef UFL_CONSTS_VH
`define UFL_CONSTS_VH

// Register offsets in bytes, relative to the block base.
`define UFL_ALLOC_LIST0 8'h00
`define UFL_DEALLOC_LIST0 8'h04
`define UFL_ALLOC_LIST1 8'h08
`define UFL_DEALLOC_LIST1 8'h0c
`define UFL_ALLOC_LIST2 8'h10
`define UFL_DEALLOC_LIST2 8'h14
`define UFL_ALLOC_LIST3 8'h18
`define UFL_DEALLOC_LIST3 8'h1c
`define UFL_REMAP_BASE 8'h20

// Free-list word layout.
`define UFL_EMPTY_BIT 0
`define UFL_EMPTY_WORD 32'h00000001

// Remap entry layout.
`define UFL_REMAP_MAP_BIT 31
`define UFL_REMAP_GROUP_LSB 5
`define UFL_REMAP_SRC_LSB 0
`define UFL_REMAP_RESET 32'h00000000
`define UFL_REMAP_KEEP_MASK 32'h800001ff

// Free-list geometry and thresholds, and remap image geometry.
`define UFL_DEPTH 512
`define UFL_ALMOST_EMPTY 4
`define UFL_GROUPS 16
`define UFL_GROUP_SOURCES 32

`endif

// ---- rtl/ufl_free_list_bank.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ufl_consts.vh"

module ufl_free_list_bank #(
	parameter DEPTH = `UFL_DEPTH,
	parameter PTR_W = 9,
	parameter [9:0] ALMOST_EMPTY = `UFL_ALMOST_EMPTY
) (
	// Clock and reset
	input wire mclk,
	input wire rstn,
	// Processor register port
	input wire [7:0] regAddr,
	input wire regRead,
	input wire regWrite,
	input wire [31:0] regWdata,
	output reg [31:0] regRdata,
	output reg regRvalid,
	// Interrupt source levels and their remapped image
	output reg [7:0] irqSource,
	output reg [511:0] irqRemapped
);

	// Entries keep bits 31:1 only, since bit 0 never carries data.
	reg [31:1] fifoMem [0:4*DEPTH-1];
	reg [PTR_W-1:0] rdPtr_reg [0:3];
	reg [PTR_W-1:0] wrPtr_reg [0:3];
	reg [PTR_W:0] count_reg [0:3];
	reg [31:0] remap_reg [0:7];

	wire flArea;
	wire [1:0] flSel;
	wire isDealloc;
	wire rmArea;
	wire [2:0] rmSel;
	wire listEmpty;
	wire listFull;
	wire doPop;
	wire doPush;
	wire [PTR_W+1:0] rdIndex;
	wire [PTR_W+1:0] wrIndex;
	wire [7:0] remapBase;
	wire [31:1] headWord;
	wire [3:0] almostEmptyNext;
	wire [3:0] notEmptyNext;
	reg [31:0] readWord;
	integer rstIdx;
	integer mapIdx;
	integer srcIdx;
	integer entIdx;

	// Zero test on an occupancy count; the empty check and the not-empty level share it.
	function cntIsZero;
		input [PTR_W:0] cnt;
		begin
			cntIsZero = (cnt == {(PTR_W+1){1'b0}});
		end
	endfunction

	// Ring pointers wrap at the depth, which the pointer width makes implicit.
	function [PTR_W-1:0] ptrStep;
		input [PTR_W-1:0] ptr;
		begin
			ptrStep = ptr + 1'b1;
		end
	endfunction

	// The four lists share one memory, the list number forming the top address bits.
	function [PTR_W+1:0] memIndex;
		input [1:0] sel;
		input [PTR_W-1:0] ptr;
		begin
			memIndex = {sel, ptr};
		end
	endfunction

	// A mapped entry keeps only the map flag, group and bit fields.
	// An unmapped entry is stored as all zero so its group and bit read back clear.
	function [31:0] remapClean;
		input [31:0] word;
		begin
			if (word[`UFL_REMAP_MAP_BIT]) begin
				remapClean = word & `UFL_REMAP_KEEP_MASK;
			end else begin
				remapClean = `UFL_REMAP_RESET;
			end
		end
	endfunction

	// Position of a source within the 512-wide image: group number above bit position.
	function [8:0] remapSlot;
		input [31:0] entry;
		begin
			remapSlot = {entry[`UFL_REMAP_GROUP_LSB+3:`UFL_REMAP_GROUP_LSB],
				entry[`UFL_REMAP_SRC_LSB+4:`UFL_REMAP_SRC_LSB]};
		end
	endfunction

	assign flArea = (regAddr[7:5] == 3'h0);
	assign flSel = regAddr[4:3];
	assign isDealloc = regAddr[2];
	assign rmArea = (regAddr[7:5] == remapBase[7:5]);
	assign rmSel = regAddr[4:2];
	assign listEmpty = cntIsZero(count_reg[flSel]);
	// A full list refuses stores, so the count never passes the depth.
	assign listFull = (count_reg[flSel] == DEPTH[PTR_W:0]);
	assign doPop = regRead && flArea && !isDealloc && !listEmpty;
	assign doPush = regWrite && flArea && isDealloc && !listFull;
	assign rdIndex = memIndex(flSel, rdPtr_reg[flSel]);
	assign wrIndex = memIndex(flSel, wrPtr_reg[flSel]);
	assign headWord = fifoMem[rdIndex];
	assign remapBase = `UFL_REMAP_BASE;

	// Zero occupancy is below any threshold, so an empty list is also almost empty.
	assign almostEmptyNext[0] = (count_reg[0] <= ALMOST_EMPTY);
	assign almostEmptyNext[1] = (count_reg[1] <= ALMOST_EMPTY);
	assign almostEmptyNext[2] = (count_reg[2] <= ALMOST_EMPTY);
	assign almostEmptyNext[3] = (count_reg[3] <= ALMOST_EMPTY);
	assign notEmptyNext[0] = !cntIsZero(count_reg[0]);
	assign notEmptyNext[1] = !cntIsZero(count_reg[1]);
	assign notEmptyNext[2] = !cntIsZero(count_reg[2]);
	assign notEmptyNext[3] = !cntIsZero(count_reg[3]);

	// The memory has no reset so it can map onto block RAM.
	always @(posedge mclk) begin
		if (doPush) begin
			// Bit 0 is never stored; a pop puts a zero back in its place.
			fifoMem[wrIndex] <= regWdata[31:1];
		end
	end

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (rstIdx = 0; rstIdx < 4; rstIdx = rstIdx + 1) begin
				rdPtr_reg[rstIdx] <= {PTR_W{1'b0}};
				wrPtr_reg[rstIdx] <= {PTR_W{1'b0}};
				count_reg[rstIdx] <= {(PTR_W+1){1'b0}};
			end
		end else begin
			// Strobes come one at a time, so a push and a pop never meet in one cycle.
			if (doPop) begin
				rdPtr_reg[flSel] <= ptrStep(rdPtr_reg[flSel]);
				count_reg[flSel] <= count_reg[flSel] - 1'b1;
			end
			if (doPush) begin
				wrPtr_reg[flSel] <= ptrStep(wrPtr_reg[flSel]);
				count_reg[flSel] <= count_reg[flSel] + 1'b1;
			end
		end
	end

	// Read mux; unmapped and write-only slots answer zero.
	always @* begin
		readWord = 32'h00000000;
		if (flArea && !isDealloc) begin
			if (listEmpty) begin
				readWord = `UFL_EMPTY_WORD;
			end else begin
				readWord = {headWord, 1'b0};
			end
		end else if (rmArea) begin
			readWord = remap_reg[rmSel];
		end
	end

	// Read answers one cycle after the strobe and holds until the next read.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			regRdata <= 32'h00000000;
			regRvalid <= 1'b0;
		end else begin
			regRvalid <= regRead;
			if (regRead) begin
				regRdata <= readWord;
			end
		end
	end

	// A cleared map flag forces group and bit to zero so the entry reads back clean.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (mapIdx = 0; mapIdx < 8; mapIdx = mapIdx + 1) begin
				remap_reg[mapIdx] <= `UFL_REMAP_RESET;
			end
		end else if (regWrite && rmArea) begin
			remap_reg[rmSel] <= remapClean(regWdata);
		end
	end

	// Source levels are registered and trail the counts by one cycle; the remapped image is built from them and trails by one more.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irqSource <= 8'h00;
			irqRemapped <= {512{1'b0}};
		end else begin
			for (srcIdx = 0; srcIdx < 4; srcIdx = srcIdx + 1) begin
				irqSource[2*srcIdx] <= almostEmptyNext[srcIdx];
				irqSource[2*srcIdx+1] <= notEmptyNext[srcIdx];
			end
			irqRemapped <= {512{1'b0}};
			for (entIdx = 0; entIdx < 8; entIdx = entIdx + 1) begin
				if (remap_reg[entIdx][`UFL_REMAP_MAP_BIT]) begin
					irqRemapped[remapSlot(remap_reg[entIdx])] <= irqSource[entIdx];
				end
			end
		end
	end

endmodule // ufl_free_list_bank
`default_nettype wire

// ---- verif/ufl_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ufl_checker (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Register port and levels
	input wire logic [7:0] regAddr,
	input wire logic regRead,
	input wire logic regWrite,
	input wire logic [31:0] regRdata,
	input wire logic regRvalid,
	input wire logic [7:0] irqSource
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	ans_a: assert property (regRead |=> regRvalid) else $error("no answer");
	hold_a: assert property (!regRead |=> !regRvalid && $stable(regRdata))
		else $error("stray answer");
	empty_word_a: assert property (regRvalid && regRdata[0] && $past(regAddr[7:5]) == 3'h0
		|-> regRdata == 32'h1) else $error("empty word");
	// The levels lag the count by a cycle, so a fresh push or pop is left out.
	empty_read_a: assert property (regRead && regAddr == 8'h00 && !irqSource[1]
		&& !$past(regWrite) |=> regRdata == 32'h1) else $error("empty read");
	pop_a: assert property (regRead && regAddr == 8'h00 && irqSource[1]
		&& !$past(regRead) |=> !regRdata[0]) else $error("pop flag");
	push_a: assert property (regWrite && regAddr == 8'h04 |-> ##2 irqSource[1])
		else $error("push lost");
	write_only_a: assert property (regRead && regAddr == 8'h04 |=> regRdata == 32'h0)
		else $error("dealloc read");
	level_a: assert property ($past(rstn) |-> irqSource[0] || irqSource[1])
		else $error("levels");
	cover property (regRvalid && regRdata[0]);
	cover property (regRvalid && !regRdata[0]);
	cover property (irqSource == 8'haa);
endmodule // ufl_checker
bind ufl_free_list_bank ufl_checker u_chk (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
	.regRead(regRead), .regWrite(regWrite), .regRdata(regRdata), .regRvalid(regRvalid),
	.irqSource(irqSource));
`default_nettype wire

// ---- verif/utility_free_list_bank_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module utility_free_list_bank_bench;
	logic mclk = 0, rstn = 0, regRead = 0, regWrite = 0, regRvalid;
	logic [7:0] regAddr = 8'h00, irqSource;
	logic [31:0] regWdata = 32'h0, regRdata;
	logic [511:0] irqRemapped;
	int num_errors = 0, cmp_count = 0, cyc = 0, i;
	always #25 mclk = ~mclk;
	ufl_free_list_bank u_dut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regRead(regRead),
		.regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
		.irqSource(irqSource), .irqRemapped(irqRemapped));
	task tally_and_finish;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk) #1;
		{regWrite, regRead, regAddr, regWdata} = {w, !w, a, d};
		@(posedge mclk) #1;
		{regWrite, regRead} = 2'h0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		acc(0, a, 32'h0);
		chk(regRvalid, 32'h1);
		chk(regRdata, exp);
	endtask
	task t_empty;
		acc(1, 8'h00, 32'h10);
		rd(8'h04, 32'h0);
		for (i = 0; i < 4; i++) rd(8'(8 * i), 32'h1);
		chk(irqSource, 8'h55);
	endtask
	task t_lists;
		for (i = 0; i < 20; i++) acc(1, 8'(8 * (i % 4) + 4), 32'(i * 16 + 1));
		@(posedge mclk) #1;
		chk(irqSource, 8'haa);
		for (i = 0; i < 20; i++) begin
			rd(8'(8 * (i % 4)), 32'(i * 16));
			if (i == 3) begin
				@(posedge mclk) #1;
				chk(irqSource, 8'hff);
			end
		end
	endtask
	task t_remap;
		acc(1, 8'h20, 32'h80000065);
		repeat (2) @(posedge mclk);
		#1 chk(irqRemapped[101], 32'h1);
		rd(8'h20, 32'h80000065);
		acc(1, 8'h24, 32'h000001ff);
		rd(8'h24, 32'h0);
	endtask
	// The extra store must vanish without disturbing the 512 held entries.
	task t_full;
		for (i = 0; i < 513; i++) acc(1, 8'h0c, 32'(i * 2));
		for (i = 0; i < 512; i++) rd(8'h08, 32'(i * 2));
		rd(8'h08, 32'h1);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		#1 rstn = 1;
		t_empty;
		t_lists;
		t_remap;
		t_full;
		tally_and_finish;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 5000) begin
			num_errors++;
			tally_and_finish;
		end
	end
endmodule // utility_free_list_bank_bench
`default_nettype wire
